// ==== logic/isr_status.sv ====
`timescale 1ns/1ns
`default_nettype none

module isr_status
  import isr_pkg::*;
(
  input  wire logic          mclk_i,          // 10 MHz clock
  input  wire logic          sys_rst_i,       // sync reset, high
  input  wire isr_cmd_t      cmd_i,           // parsed status command
  output logic               cmd_ready_o,     // ready to take a command
  output isr_rsp_t           rsp_o,           // query answer
  input  wire logic [QW-1:0] questionable_summary_cond_i,     // live questionable condition
  input  wire logic [QW-1:0] oper_cond_i,     // live operation condition
  input  wire logic [BW-1:0] std_evt_i,       // standard error pulses
  input  wire logic          pend_busy_i,     // overlapped work outstanding
  input  wire logic          oq_nonempty_i,   // output queue holds data
  input  wire logic          errq_nonempty_i, // error queue holds entries
  input  wire logic          dev_clear_i,     // device clear pulse
  output logic [BW-1:0]      status_byte_o,   // live status byte
  output logic               srq_o,           // service request
  output logic               oq_flush_o,      // empty output queue pulse
  output logic               errq_clear_o,    // empty error queue pulse
  output logic               oq_push_o,       // push byte pulse
  output logic [7:0]         oq_byte_o        // byte to push
);

  isr_state_t s_reg;
  isr_state_t s_next;

  // transition filter shared by both condition groups
  function automatic logic [QW-1:0] edge_hits(input logic [QW-1:0] prev, input logic [QW-1:0] cur,
                                              input logic [QW-1:0] fall, input logic [QW-1:0] rise);
    edge_hits = (prev & ~cur & fall) | (~prev & cur & rise);
  endfunction

  logic          questionable_summary_sum;
  logic          oper_sum;
  logic          esb_sum;
  logic          mss;
  logic [BW-1:0] sbyte;
  logic [QW-1:0] q_hits;
  logic [QW-1:0] o_hits;
  logic [BW-1:0] se_hits;
  logic          take;

  // summaries are pure combinational, so mask writes show on the next edge
  assign questionable_summary_sum = |(s_reg.qevt & s_reg.qenab);
  assign oper_sum = |(s_reg.oevt & s_reg.oenab);
  assign esb_sum  = |(s_reg.ses & s_reg.see);
  always_comb begin
    sbyte          = '0;
    sbyte[SB_OPER] = oper_sum;
    sbyte[SB_ESB]  = esb_sum;
    sbyte[SB_MAV]  = oq_nonempty_i;
    sbyte[SB_QSUM] = questionable_summary_sum;
    sbyte[SB_ERR]  = errq_nonempty_i;
    mss            = |(sbyte & s_reg.svc_en);
    sbyte[SB_MSS]  = mss;
  end

  assign q_hits  = edge_hits(s_reg.qprev, questionable_summary_cond_i, s_reg.qfall, s_reg.qrise);
  assign o_hits  = edge_hits(s_reg.oprev, oper_cond_i, s_reg.ofall, s_reg.orise);
  assign se_hits = std_evt_i & SE_EXT_MASK;
  assign take    = cmd_i.valid && (s_reg.mode == ISR_RUN);

  always_comb begin
    s_next            = s_reg;
    s_next.qprev      = questionable_summary_cond_i;
    s_next.oprev      = oper_cond_i;
    s_next.rsp        = '0;
    s_next.oq_flush   = 1'b0;
    s_next.errq_clear = 1'b0;
    s_next.oq_push    = 1'b0;
    s_next.mss_prev   = mss;

    if (take) begin
      unique case (cmd_i.op)
        ISR_QENAB_WR: s_next.qenab = cmd_i.data;
        ISR_QFALL_WR: s_next.qfall = cmd_i.data;
        ISR_QRISE_WR: s_next.qrise = cmd_i.data;
        ISR_OENAB_WR: s_next.oenab = cmd_i.data;
        ISR_OFALL_WR: s_next.ofall = cmd_i.data;
        ISR_ORISE_WR: s_next.orise = cmd_i.data;
        ISR_SEE_WR:   s_next.see   = cmd_i.data[BW-1:0];
        ISR_SVC_WR:   s_next.svc_en = cmd_i.data[BW-1:0];
        ISR_QENAB_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.qenab};
        ISR_QFALL_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.qfall};
        ISR_QRISE_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.qrise};
        ISR_OENAB_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.oenab};
        ISR_OFALL_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.ofall};
        ISR_ORISE_RD: s_next.rsp = '{valid: 1'b1, data: s_reg.orise};
        ISR_SEE_RD:   s_next.rsp = '{valid: 1'b1, data: {8'h00, s_reg.see}};
        ISR_SVC_RD:   s_next.rsp = '{valid: 1'b1, data: {8'h00, s_reg.svc_en}};
        ISR_QEVT_RD: begin
          s_next.rsp  = '{valid: 1'b1, data: s_reg.qevt};
          s_next.qevt = '0;
        end
        ISR_OEVT_RD: begin
          s_next.rsp  = '{valid: 1'b1, data: s_reg.oevt};
          s_next.oevt = '0;
        end
        ISR_SES_RD: begin
          s_next.rsp = '{valid: 1'b1, data: {8'h00, s_reg.ses}};
          s_next.ses = '0;
        end
        ISR_SBYTE_RD: s_next.rsp = '{valid: 1'b1, data: {8'h00, sbyte}};
        ISR_SPOLL: begin
          s_next.rsp = '{valid: 1'b1, data: {8'h00, sbyte[7], s_reg.rqs, sbyte[5:0]}};
          s_next.rqs = 1'b0;
        end
        ISR_PRESET: begin
          s_next.qenab = ISR_ENAB_PRESET;
          s_next.qfall = ISR_FALL_PRESET;
          s_next.qrise = ISR_RISE_PRESET;
          s_next.oenab = ISR_ENAB_PRESET;
          s_next.ofall = ISR_FALL_PRESET;
          s_next.orise = ISR_RISE_PRESET;
        end
        ISR_CLS: begin
          s_next.ses        = '0;
          s_next.qevt       = '0;
          s_next.oevt       = '0;
          s_next.rqs        = 1'b0;
          s_next.errq_clear = 1'b1;
          s_next.oq_flush   = cmd_i.after_term;
        end
        ISR_OPC:   s_next.opc_pend = 1'b1;
        ISR_OPC_Q: s_next.mode = ISR_HOLD_OPQ;
        ISR_WAI:   s_next.mode = ISR_HOLD_WAI;
        default: ;
      endcase
    end

    // pending work is one level from the overlapped command engine
    if (s_reg.opc_pend && !pend_busy_i) begin
      s_next.opc_pend = 1'b0;
      s_next.ses[SE_OPC] = 1'b1;
    end
    unique case (s_reg.mode)
      ISR_RUN: ;
      ISR_HOLD_WAI: begin
        if (!pend_busy_i || dev_clear_i) begin
          s_next.mode = ISR_RUN;
        end
      end
      ISR_HOLD_OPQ: begin
        if (dev_clear_i) begin
          s_next.mode = ISR_RUN;
        end else if (!pend_busy_i) begin
          s_next.mode    = ISR_RUN;
          s_next.oq_push = 1'b1;
        end
      end
      default: s_next.mode = ISR_RUN;
    endcase

    // hardware sets after any clear so an event in a read cycle survives
    s_next.qevt = s_next.qevt | q_hits;
    s_next.oevt = s_next.oevt | o_hits;
    s_next.ses  = s_next.ses | se_hits;
    // a fresh reason for service raises the request flag
    if (mss && !s_reg.mss_prev) begin
      s_next.rqs = 1'b1;
    end
    // only clears here; a poll or clear-status drop is undone only by a fresh mss rise in the same cycle
    if (!mss && s_reg.svc_en == '0) begin
      s_next.rqs = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_reg       <= '0;
      s_reg.qfall <= ISR_FALL_PRESET;
      s_reg.qrise <= ISR_RISE_PRESET;
      s_reg.ofall <= ISR_FALL_PRESET;
      s_reg.orise <= ISR_RISE_PRESET;
      s_reg.ses   <= SE_RESET;
      s_reg.mode  <= ISR_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready_o   = (s_reg.mode == ISR_RUN);
  assign rsp_o         = s_reg.rsp;
  assign status_byte_o = sbyte;
  assign srq_o         = s_reg.rqs;
  assign oq_flush_o    = s_reg.oq_flush;
  assign errq_clear_o  = s_reg.errq_clear;
  assign oq_push_o     = s_reg.oq_push;
  assign oq_byte_o     = ISR_ASCII_ONE;

  property p_questionable_summary_sum;
    @(posedge mclk_i) disable iff (sys_rst_i)
      status_byte_o[SB_QSUM] == |(s_reg.qevt & s_reg.qenab);
  endproperty
  a_questionable_summary_sum: assert property (p_questionable_summary_sum) else $error("questionable summary wrong");

  property p_preset;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_PRESET |=> s_reg.qenab == 16'h0000 && s_reg.qfall == 16'h0000
                                          && s_reg.qrise == 16'h7FFF;
  endproperty
  a_preset: assert property (p_preset) else $error("preset values wrong");

  property p_rise_latch;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (|(~s_reg.qprev & questionable_summary_cond_i & s_reg.qrise)) |=> (|s_reg.qevt);
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("rising change lost");

  property p_no_filter;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (s_reg.qfall[3] == 1'b0 && s_reg.qrise[3] == 1'b0 && !s_reg.qevt[3]) |=> !s_reg.qevt[3];
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unfiltered bit latched");

  property p_ses_clear;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_SES_RD && std_evt_i == 8'h00 && !s_reg.opc_pend
        |=> rsp_o.valid && rsp_o.data[7:0] == $past(s_reg.ses) && s_reg.ses == 8'h00;
  endproperty
  a_ses_clear: assert property (p_ses_clear) else $error("event read did not clear");

  property p_opc_wait;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_OPC && !s_reg.ses[SE_OPC] ##1 pend_busy_i[*3] |=> !s_reg.ses[SE_OPC];
  endproperty
  a_opc_wait: assert property (p_opc_wait) else $error("opc set while busy");

  property p_wai_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_WAI && pend_busy_i ##1 (pend_busy_i && !dev_clear_i) |=> !cmd_ready_o;
  endproperty
  a_wai_hold: assert property (p_wai_hold) else $error("wait released early");

  property p_opcq_push;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_reg.mode == ISR_HOLD_OPQ && !pend_busy_i && !dev_clear_i |=> oq_push_o && cmd_ready_o;
  endproperty
  a_opcq_push: assert property (p_opcq_push) else $error("opc query did not answer");

  property p_sre_zero;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_reg.svc_en == 8'h00 ##1 s_reg.svc_en == 8'h00 |-> !status_byte_o[SB_MSS];
  endproperty
  a_sre_zero: assert property (p_sre_zero) else $error("service summary without mask");

  property p_spoll;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_SPOLL && !(mss && !s_reg.mss_prev)
        |=> rsp_o.data[SB_MSS] == $past(s_reg.rqs) && !srq_o;
  endproperty
  a_spoll: assert property (p_spoll) else $error("serial poll flag wrong");

  property p_cls;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_CLS && q_hits == '0 |=> s_reg.qevt == '0 && errq_clear_o
                                                     && oq_flush_o == $past(cmd_i.after_term);
  endproperty
  a_cls: assert property (p_cls) else $error("clear status incomplete");

  property p_cls_rqs;
    @(posedge mclk_i) disable iff (sys_rst_i)
      take && cmd_i.op == ISR_CLS && !(mss && !s_reg.mss_prev) |=> !srq_o;
  endproperty
  a_cls_rqs: assert property (p_cls_rqs) else $error("clear status left service request");

endmodule

`default_nettype wire

// ==== include/isr_pkg.sv ====
package isr_pkg;

  localparam int QW = 16;
  localparam int BW = 8;

  // status preset values
  localparam logic [QW-1:0] ISR_ENAB_PRESET = 16'h0000;
  localparam logic [QW-1:0] ISR_FALL_PRESET = 16'h0000;
  localparam logic [QW-1:0] ISR_RISE_PRESET = 16'h7FFF;

  // standard event register fields
  localparam int SE_PON = 7;
  localparam int SE_CME = 5;
  localparam int SE_EXE = 4;
  localparam int SE_DDE = 3;
  localparam int SE_QUE = 2;
  localparam int SE_OPC = 0;
  localparam logic [BW-1:0] SE_EXT_MASK = 8'h3C;
  localparam logic [BW-1:0] SE_RESET    = 8'h80;

  // status byte fields
  localparam int SB_OPER = 7;
  localparam int SB_MSS  = 6;
  localparam int SB_ESB  = 5;
  localparam int SB_MAV  = 4;
  localparam int SB_QSUM = 3;
  localparam int SB_ERR  = 2;

  localparam logic [7:0] ISR_ASCII_ONE = 8'h31;

  typedef enum logic [4:0] {
    ISR_NOP      = 5'h00,
    ISR_QENAB_WR = 5'h01,
    ISR_QENAB_RD = 5'h02,
    ISR_QFALL_WR = 5'h03,
    ISR_QFALL_RD = 5'h04,
    ISR_QRISE_WR = 5'h05,
    ISR_QRISE_RD = 5'h06,
    ISR_QEVT_RD  = 5'h07,
    ISR_OENAB_WR = 5'h08,
    ISR_OENAB_RD = 5'h09,
    ISR_OFALL_WR = 5'h0A,
    ISR_OFALL_RD = 5'h0B,
    ISR_ORISE_WR = 5'h0C,
    ISR_ORISE_RD = 5'h0D,
    ISR_OEVT_RD  = 5'h0E,
    ISR_PRESET   = 5'h0F,
    ISR_CLS      = 5'h10,
    ISR_SEE_WR   = 5'h11,
    ISR_SEE_RD   = 5'h12,
    ISR_SES_RD   = 5'h13,
    ISR_OPC      = 5'h14,
    ISR_OPC_Q    = 5'h15,
    ISR_SVC_WR   = 5'h16,
    ISR_SVC_RD   = 5'h17,
    ISR_SBYTE_RD = 5'h18,
    ISR_SPOLL    = 5'h19,
    ISR_WAI      = 5'h1A
  } isr_op_t;

  typedef enum logic [1:0] {
    ISR_RUN      = 2'b00,
    ISR_HOLD_WAI = 2'b01,
    ISR_HOLD_OPQ = 2'b10
  } isr_mode_t;

  typedef struct packed {
    logic            valid;
    isr_op_t         op;
    logic [QW-1:0]   data;
    logic            after_term;
  } isr_cmd_t;

  typedef struct packed {
    logic            valid;
    logic [QW-1:0]   data;
  } isr_rsp_t;

  typedef struct packed {
    logic [QW-1:0]   qenab;
    logic [QW-1:0]   qfall;
    logic [QW-1:0]   qrise;
    logic [QW-1:0]   qevt;
    logic [QW-1:0]   qprev;
    logic [QW-1:0]   oenab;
    logic [QW-1:0]   ofall;
    logic [QW-1:0]   orise;
    logic [QW-1:0]   oevt;
    logic [QW-1:0]   oprev;
    logic [BW-1:0]   see;
    logic [BW-1:0]   ses;
    logic [BW-1:0]   svc_en;
    logic            rqs;
    logic            mss_prev;
    logic            opc_pend;
    isr_mode_t       mode;
    isr_rsp_t        rsp;
    logic            oq_flush;
    logic            errq_clear;
    logic            oq_push;
  } isr_state_t;

endpackage

// ==== verif/isr_ctrl_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module isr_ctrl_model
  import isr_pkg::*;
(
  input  wire logic     mclk_i,      // instrument clock
  input  wire logic     cmd_ready_i, // block takes commands
  input  wire isr_rsp_t rsp_i,       // query answer
  output var isr_cmd_t  cmd_o,       // command offered
  output var logic      dev_clear_o  // device clear pulse
);
  initial begin
    cmd_o = '0;
    dev_clear_o = 1'b0;
  end

  // held until taken; answer picked up in the cycle after
  task automatic issue(input isr_op_t op, input logic [QW-1:0] wdata, input logic term,
                       output logic [QW-1:0] rdata, output logic rv);
    int n;
    n = 0;
    @(negedge mclk_i);
    cmd_o <= '{valid: 1'b1, op: op, data: wdata, after_term: term};
    // ready seen mid-cycle holds for the coming edge, which takes it once
    while (cmd_ready_i !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    @(negedge mclk_i);
    rv = rsp_i.valid;
    rdata = rsp_i.data;
    // released bus shows inverted data, not the stale word
    cmd_o <= '{valid: 1'b0, op: ISR_NOP, data: ~wdata, after_term: ~term};
  endtask

  // only a device clear may cancel a pending wait
  task automatic dev_clear();
    @(negedge mclk_i);
    dev_clear_o <= 1'b1;
    @(negedge mclk_i);
    dev_clear_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== verif/isr_status_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module isr_status_tb_top
  import isr_pkg::*;
;
  logic          mclk_i, sys_rst_i, cmd_ready, busy, oqn, errqn, dclr;
  logic          srq, flush, errclr, push;
  logic [QW-1:0] qc, oc, d;
  logic [BW-1:0] sev, sbyte, obyte, pushed;
  logic [2:0]    seen;
  isr_cmd_t      cmd;
  isr_rsp_t      rsp;
  int            n_errors, checks_done, cyc;

  isr_status dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
    .rsp_o(rsp), .questionable_summary_cond_i(qc), .oper_cond_i(oc), .std_evt_i(sev), .pend_busy_i(busy),
    .oq_nonempty_i(oqn), .errq_nonempty_i(errqn), .dev_clear_i(dclr), .status_byte_o(sbyte),
    .srq_o(srq), .oq_flush_o(flush), .errq_clear_o(errclr), .oq_push_o(push), .oq_byte_o(obyte));

  isr_ctrl_model ctl (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready), .rsp_i(rsp), .cmd_o(cmd),
    .dev_clear_o(dclr));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // pulses are one cycle wide, so keep a sticky copy
  always @(posedge mclk_i) begin
    seen <= seen | {push, errclr, flush};
    if (push === 1'b1) pushed <= obyte;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic rd(input isr_op_t op, output logic [QW-1:0] r);
    logic v;
    ctl.issue(op, 16'h0000, 1'b0, r, v);
    if (v !== 1'b1) r = 'x;
  endtask

  task automatic wr(input isr_op_t op, input logic [QW-1:0] v, input logic term = 1'b0);
    logic [QW-1:0] r;
    logic rv;
    ctl.issue(op, v, term, r, rv);
  endtask

  task automatic t_preset();
    rd(ISR_SES_RD, d); `CHK("ses power-on", 16'h0080, d);
    rd(ISR_SES_RD, d); `CHK("ses after read", 16'h0000, d);
    wr(ISR_QENAB_WR, 16'hFFFF);
    wr(ISR_QFALL_WR, 16'hFFFF);
    wr(ISR_QRISE_WR, 16'h0000);
    wr(ISR_OENAB_WR, 16'hFFFF);
    wr(ISR_OFALL_WR, 16'hFFFF);
    wr(ISR_ORISE_WR, 16'h0000);
    rd(ISR_OFALL_RD, d); `CHK("ofall written", 16'hFFFF, d);
    rd(ISR_ORISE_RD, d); `CHK("orise written", 16'h0000, d);
    wr(ISR_PRESET, 16'h0000);
    rd(ISR_QENAB_RD, d); `CHK("qenab", 16'h0000, d);
    rd(ISR_QFALL_RD, d); `CHK("qfall", 16'h0000, d);
    rd(ISR_QRISE_RD, d); `CHK("qrise", 16'h7FFF, d);
    rd(ISR_OENAB_RD, d); `CHK("oenab", 16'h0000, d);
    rd(ISR_OFALL_RD, d); `CHK("ofall preset", 16'h0000, d);
    rd(ISR_ORISE_RD, d); `CHK("orise preset", 16'h7FFF, d);
  endtask

  // bit0 rise only, bit1 fall only, bit2 both, bit3 neither
  task automatic t_filters();
    wr(ISR_QRISE_WR, 16'h0005);
    wr(ISR_QFALL_WR, 16'h0006);
    qc = 16'h000F;
    tk(3);
    rd(ISR_QEVT_RD, d); `CHK("qevt rise", 16'h0005, d);
    qc = 16'h0000;
    tk(3);
    rd(ISR_QEVT_RD, d); `CHK("qevt fall", 16'h0006, d);
    rd(ISR_QEVT_RD, d); `CHK("qevt cleared", 16'h0000, d);
    qc = 16'h0008;
    tk(3);
    rd(ISR_QEVT_RD, d); `CHK("qevt no filter", 16'h0000, d);
    qc = 16'h0004;
    tk(3);
    rd(ISR_QEVT_RD, d); `CHK("qevt both", 16'h0004, d);
  endtask

  task automatic t_summary();
    qc = 16'h0001;
    tk(3);
    wr(ISR_QENAB_WR, 16'h0001);
    `CHK("questionable_summary summary", 1'b1, sbyte[SB_QSUM]);
    wr(ISR_QENAB_WR, 16'h0000);
    `CHK("questionable_summary masked", 1'b0, sbyte[SB_QSUM]);
    wr(ISR_QENAB_WR, 16'h0001);
    tk(3);
    `CHK("srq off", 1'b0, srq);
    wr(ISR_SVC_WR, 16'h0008);
    `CHK("mss", 1'b1, sbyte[SB_MSS]);
    tk(2);
    `CHK("srq on", 1'b1, srq);
    rd(ISR_SVC_RD, d); `CHK("svc mask", 16'h0008, d);
    rd(ISR_SPOLL, d); `CHK("poll", 16'h0048, d);
    `CHK("srq polled", 1'b0, srq);
    `CHK("mss kept", 1'b1, sbyte[SB_MSS]);
    rd(ISR_SBYTE_RD, d); `CHK("sbyte", 16'h0048, d);
    rd(ISR_SBYTE_RD, d); `CHK("sbyte again", 16'h0048, d);
    rd(ISR_QEVT_RD, d);
    `CHK("summaries gone", 8'h00, sbyte & 8'h48);
    wr(ISR_OENAB_WR, 16'h0020);
    oc = 16'h0020;
    tk(3);
    `CHK("oper summary", 1'b1, sbyte[SB_OPER]);
    rd(ISR_OEVT_RD, d); `CHK("oevt", 16'h0020, d);
    `CHK("oper cleared", 1'b0, sbyte[SB_OPER]);
  endtask

  task automatic t_std();
    wr(ISR_SEE_WR, 16'h0010);
    sev = 8'h3C;
    tk(1);
    sev = 8'h00;
    tk(1);
    `CHK("esb", 1'b1, sbyte[SB_ESB]);
    rd(ISR_SES_RD, d); `CHK("ses errors", 16'h003C, d);
    `CHK("esb cleared", 1'b0, sbyte[SB_ESB]);
  endtask

  task automatic t_opc();
    busy = 1'b1;
    wr(ISR_OPC, 16'h0000);
    rd(ISR_SEE_RD, d); `CHK("no stall", 16'h0010, d);
    rd(ISR_SES_RD, d); `CHK("opc pending", 16'h0000, d);
    busy = 1'b0;
    tk(3);
    rd(ISR_SES_RD, d); `CHK("opc done", 16'h0001, d);
  endtask

  task automatic t_hold();
    busy = 1'b1;
    wr(ISR_OPC_Q, 16'h0000);
    seen = 3'b000;
    tk(3);
    `CHK("opcq blocks", 1'b0, cmd_ready);
    busy = 1'b0;
    tk(3);
    `CHK("opcq pushed", 1'b1, seen[2]);
    `CHK("opcq byte", 8'h31, pushed);
    `CHK("opcq resumes", 1'b1, cmd_ready);
    busy = 1'b1;
    wr(ISR_WAI, 16'h0000);
    tk(4);
    `CHK("wai blocks", 1'b0, cmd_ready);
    ctl.dev_clear();
    tk(2);
    `CHK("wai cancelled", 1'b1, cmd_ready);
    wr(ISR_WAI, 16'h0000);
    `CHK("wai held", 1'b0, cmd_ready);
    busy = 1'b0;
    tk(3);
    `CHK("wai done", 1'b1, cmd_ready);
  endtask

  task automatic t_cls();
    oqn = 1'b1;
    errqn = 1'b1;
    tk(1);
    `CHK("mav err", 8'h14, sbyte & 8'h14);
    qc = 16'h0000;
    oc = 16'h0000;
    tk(2);
    qc = 16'h0001;
    oc = 16'h0020;
    sev = 8'h20;
    tk(1);
    sev = 8'h00;
    tk(2);
    seen = 3'b000;
    wr(ISR_CLS, 16'h0000, 1'b1);
    tk(1);
    `CHK("cls pulses", 3'b011, seen);
    `CHK("cls byte", 8'h00, sbyte & 8'hE8);
    `CHK("cls srq", 1'b0, srq);
    rd(ISR_QEVT_RD, d); `CHK("cls qevt", 16'h0000, d);
    rd(ISR_OEVT_RD, d); `CHK("cls oevt", 16'h0000, d);
    rd(ISR_SES_RD, d); `CHK("cls ses", 16'h0000, d);
    seen = 3'b000;
    wr(ISR_CLS, 16'h0000, 1'b0);
    tk(1);
    `CHK("cls no flush", 3'b010, seen);
    oqn = 1'b0;
    tk(1);
    `CHK("mav empty", 1'b0, sbyte[SB_MAV]);
  endtask

  initial begin
    {sys_rst_i, busy, oqn, errqn} = 4'b1000;
    {qc, oc, sev, seen, pushed} = '0;
    {n_errors, checks_done, cyc} = '0;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_preset();
    t_filters();
    t_summary();
    t_std();
    t_opc();
    t_hold();
    t_cls();
    end_sim();
  end
endmodule

`default_nettype wire
